// ### logic/epm_cfg.svh
// constants for the eeprom pin mux, strap and reset block
`ifndef EPM_CFG_SVH
`define EPM_CFG_SVH
`define EPM_FUNC_EEPROM  2'h0
`define EPM_FUNC_GPO     2'h1
`define EPM_FUNC_MON_A   2'h2
`define EPM_FUNC_MON_B   2'h3
`define EPM_STRAP_RST    1'b0
`define EPM_REF_MHZ      25
`define EPM_POR_CYCLES   16
`define EPM_POR_W        5
`endif

// ### logic/epm_pin_mux.sv
// pin mux for eeprom pins, bus width strap, reset and pair swap
`include "epm_cfg.svh"
module epm_pin_mux (
    input  wire logic               clk_i,
    input  wire logic               rst_i,
    input  wire logic               reset_in_n_i,
    input  wire epm_pkg::epm_func_e data_func_i,
    input  wire epm_pkg::epm_func_e clock_func_i,
    input  wire logic               func_load_i,
    input  wire logic               ee_cs_req_i,
    input  wire logic               ee_clk_req_i,
    input  wire logic               ee_dout_i,
    input  wire logic               ee_doe_i,
    input  wire logic               general_output_a_i,
    input  wire logic               general_output_b_i,
    input  wire logic               mii_tx_en_i,
    input  wire logic               mii_tx_clk_i,
    input  wire logic               mii_rx_dv_i,
    input  wire logic               mii_rx_clk_i,
    input  wire logic               eeprom_data_pin_i,
    output logic                    eeprom_data_pin_o,
    output logic                    eeprom_data_pin_oe_n_o,
    output logic                    eeprom_clock_pin_o,
    output logic                    eeprom_chip_select_o,
    output logic                    ee_din_o,
    output logic                    bus_width_32_o,
    input  wire logic               host_rd_i,
    input  wire logic               host_wr_i,
    input  wire logic               power_save_exit_i,
    output logic                    host_wr_ok_o,
    input  wire logic               crossover_enable_strap_i,
    input  wire logic               reversal_detected_i,
    input  wire logic               reversal_manual_i,
    output logic                    pair_swap_o,
    output logic                    sys_rst_o
);
    import epm_pkg::*;

    // power-on counter, reset pin and strap synchronisers
    logic [`EPM_POR_W-1:0] por_q, por_d;
    logic [1:0]            rstn_sync_q, rstn_sync_d;
    logic [1:0]            strap_sync_q, strap_sync_d;
    logic [1:0]            xov_sync_q, xov_sync_d;
    logic [1:0]            rev_sync_q, rev_sync_d;
    logic [1:0]            man_sync_q, man_sync_d;
    logic                  int_rst;
    logic                  int_rst_q, int_rst_d;
    logic                  strap_q, strap_d;
    logic                  xov_q, xov_d;
    epm_func_e             dfunc_q, dfunc_d;
    epm_func_e             cfunc_q, cfunc_d;
    epm_wr_e               wr_q, wr_d;
    logic                  dout_q, dout_d;
    logic                  doen_q, doen_d;
    logic                  cout_q, cout_d;
    logic                  cs_q, cs_d;
    logic                  din_q, din_d;
    logic                  swap_q, swap_d;

    // borrowed pin check, shared by both pins
    function automatic logic borrowed(input epm_func_e f);
        borrowed = (f != EPM_EEPROM);
    endfunction

    // internal reset: por count plus synchronised pin
    always_comb begin
        por_d        = (por_q == `EPM_POR_W'(`EPM_POR_CYCLES)) ? por_q : por_q + `EPM_POR_W'(1);
        rstn_sync_d  = {rstn_sync_q[0], reset_in_n_i};
        strap_sync_d = {strap_sync_q[0], eeprom_data_pin_i};
        xov_sync_d   = {xov_sync_q[0], crossover_enable_strap_i};
        rev_sync_d   = {rev_sync_q[0], reversal_detected_i};
        man_sync_d   = {man_sync_q[0], reversal_manual_i};
        int_rst_d    = !rstn_sync_q[1] || (por_q != `EPM_POR_W'(`EPM_POR_CYCLES));
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            por_q        <= '0;
            rstn_sync_q  <= 2'b00;
            strap_sync_q <= 2'b00;
            xov_sync_q   <= 2'b00;
            rev_sync_q   <= 2'b00;
            man_sync_q   <= 2'b00;
            int_rst_q    <= 1'b1;
        end else begin
            por_q        <= por_d;
            rstn_sync_q  <= rstn_sync_d;
            strap_sync_q <= strap_sync_d;
            xov_sync_q   <= xov_sync_d;
            rev_sync_q   <= rev_sync_d;
            man_sync_q   <= man_sync_d;
            int_rst_q    <= int_rst_d;
        end
    end

    assign int_rst = int_rst_q;

    // main state; straps keep sampling during reset so release freezes them
    always_comb begin
        strap_d = int_rst ? strap_sync_q[1] : strap_q;
        xov_d   = int_rst ? xov_sync_q[1] : xov_q;
        dfunc_d = dfunc_q;
        cfunc_d = cfunc_q;
        if (int_rst) begin
            dfunc_d = EPM_EEPROM;
            cfunc_d = EPM_EEPROM;
        end else if (func_load_i) begin
            dfunc_d = data_func_i;
            cfunc_d = clock_func_i;
        end
        // first read unlocks writes; power save exit relocks
        case (wr_q)
            EPM_ST_RESET:  wr_d = int_rst ? EPM_ST_RESET : EPM_ST_LOCKED;
            EPM_ST_LOCKED: wr_d = host_rd_i ? EPM_ST_OPEN : EPM_ST_LOCKED;
            EPM_ST_OPEN:   wr_d = power_save_exit_i ? EPM_ST_LOCKED : EPM_ST_OPEN;
            default:       wr_d = EPM_ST_RESET;
        endcase
        if (int_rst) begin
            wr_d = EPM_ST_RESET;
        end
        // data pin: strap must not be driven while reset holds it
        dout_d = 1'b0;
        doen_d = 1'b1;
        if (!int_rst) begin
            case (dfunc_q)
                EPM_EEPROM: begin
                    dout_d = ee_dout_i;
                    doen_d = !ee_doe_i;
                end
                EPM_GPO: begin
                    dout_d = general_output_a_i;
                    doen_d = 1'b0;
                end
                EPM_MON_A: begin
                    dout_d = mii_tx_en_i;
                    doen_d = 1'b0;
                end
                EPM_MON_B: begin
                    dout_d = mii_tx_clk_i;
                    doen_d = 1'b0;
                end
                default: begin
                    dout_d = 1'b0;
                    doen_d = 1'b1;
                end
            endcase
        end
        case (cfunc_q)
            EPM_EEPROM: cout_d = ee_clk_req_i;
            EPM_GPO:    cout_d = general_output_b_i;
            EPM_MON_A:  cout_d = mii_rx_dv_i;
            EPM_MON_B:  cout_d = mii_rx_clk_i;
            default:    cout_d = 1'b0;
        endcase
        if (int_rst) begin
            cout_d = 1'b0;
        end
        cs_d   = ee_cs_req_i && !int_rst && !borrowed(dfunc_q) && !borrowed(cfunc_q);
        din_d  = (dfunc_q == EPM_EEPROM) ? strap_sync_q[1] : 1'b0;
        swap_d = int_rst ? 1'b0 : ((xov_q && rev_sync_q[1]) || man_sync_q[1]);
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            strap_q <= `EPM_STRAP_RST;
            xov_q   <= 1'b0;
            dfunc_q <= EPM_EEPROM;
            cfunc_q <= EPM_EEPROM;
            wr_q    <= EPM_ST_RESET;
            dout_q  <= 1'b0;
            doen_q  <= 1'b1;
            cout_q  <= 1'b0;
            cs_q    <= 1'b0;
            din_q   <= 1'b0;
            swap_q  <= 1'b0;
        end else begin
            strap_q <= strap_d;
            xov_q   <= xov_d;
            dfunc_q <= dfunc_d;
            cfunc_q <= cfunc_d;
            wr_q    <= wr_d;
            dout_q  <= dout_d;
            doen_q  <= doen_d;
            cout_q  <= cout_d;
            cs_q    <= cs_d;
            din_q   <= din_d;
            swap_q  <= swap_d;
        end
    end

    // outputs; write permit is a handshake term, so combinational
    assign eeprom_data_pin_o      = dout_q;
    assign eeprom_data_pin_oe_n_o = doen_q;
    assign eeprom_clock_pin_o     = cout_q;
    assign eeprom_chip_select_o   = cs_q;
    assign ee_din_o               = din_q;
    assign bus_width_32_o         = strap_q;
    assign host_wr_ok_o           = (wr_q == EPM_ST_OPEN) && host_wr_i;
    assign pair_swap_o            = swap_q;
    assign sys_rst_o              = int_rst_q;

    // chip select never follows a borrowed pin
    property p_cs_borrowed;
        @(posedge clk_i) disable iff (rst_i)
        (borrowed(dfunc_q) || borrowed(cfunc_q)) |=> !eeprom_chip_select_o;
    endproperty
    a_cs_borrowed: assert property (p_cs_borrowed) else $error("chip select while pin borrowed");

    property p_cs_clk;
        @(posedge clk_i) disable iff (rst_i)
        (cfunc_q == EPM_GPO) |=> !eeprom_chip_select_o;
    endproperty
    a_cs_clk: assert property (p_cs_clk) else $error("chip select while clock pin is gpo");

    property p_gpo_drives;
        @(posedge clk_i) disable iff (rst_i || int_rst)
        (dfunc_q == EPM_GPO) && $stable(dfunc_q) |=> !eeprom_data_pin_oe_n_o;
    endproperty
    a_gpo_drives: assert property (p_gpo_drives) else $error("gpo not driving data pin");

    property p_strap_hold;
        @(posedge clk_i) disable iff (rst_i)
        !int_rst && !$past(int_rst) |-> $stable(bus_width_32_o);
    endproperty
    a_strap_hold: assert property (p_strap_hold) else $error("strap changed after release");

    property p_strap_take;
        @(posedge clk_i) disable iff (rst_i)
        $fell(int_rst) |-> bus_width_32_o == $past(strap_sync_q[1]);
    endproperty
    a_strap_take: assert property (p_strap_take) else $error("strap not latched at release");

    property p_wr_locked;
        @(posedge clk_i) disable iff (rst_i)
        $fell(int_rst) |-> !host_wr_ok_o [*2];
    endproperty
    a_wr_locked: assert property (p_wr_locked) else $error("write allowed before first read");

    property p_wr_open;
        @(posedge clk_i) disable iff (rst_i || int_rst)
        (wr_q == EPM_ST_LOCKED) && host_rd_i && !power_save_exit_i ##1 host_wr_i |-> host_wr_ok_o;
    endproperty
    a_wr_open: assert property (p_wr_open) else $error("write refused after read");

    property p_swap;
        @(posedge clk_i) disable iff (rst_i || int_rst)
        man_sync_q[1] |=> pair_swap_o;
    endproperty
    a_swap: assert property (p_swap) else $error("manual reversal not applied");

    property p_rst_pin;
        @(posedge clk_i) disable iff (rst_i)
        !rstn_sync_q[1] |=> sys_rst_o ##1 (dfunc_q == EPM_EEPROM);
    endproperty
    a_rst_pin: assert property (p_rst_pin) else $error("reset pin ignored");
endmodule

// ### logic/epm_pkg.sv
// types for the eeprom pin mux, strap and reset block
`include "epm_cfg.svh"
package epm_pkg;
    typedef enum logic [1:0] {
        EPM_EEPROM = 2'b00,
        EPM_GPO    = 2'b01,
        EPM_MON_A  = 2'b10,
        EPM_MON_B  = 2'b11
    } epm_func_e;
    typedef enum logic [1:0] {
        EPM_ST_RESET   = 2'b00,
        EPM_ST_LOCKED  = 2'b01,
        EPM_ST_OPEN    = 2'b10
    } epm_wr_e;
endpackage

// ### verification/eeprom_pin_mux_strap_reset_tb_top.sv
// self-checking bench for the eeprom pin mux, strap and reset block
module eeprom_pin_mux_strap_reset_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import epm_pkg::*;
    logic        clk_i = 0, rst_i = 1, reset_in_n_i = 1, func_load_i = 0, strap_lvl = 0, read_phase = 0;
    epm_func_e   data_func_i = EPM_EEPROM, clock_func_i = EPM_EEPROM;
    logic        ee_cs_req_i = 0, ee_clk_req_i = 0, ee_dout_i = 0, ee_doe_i = 0;
    logic        general_output_a_i = 0, general_output_b_i = 0, host_rd_i = 0, host_wr_i = 0;
    logic        mii_tx_en_i = 0, mii_tx_clk_i = 0, mii_rx_dv_i = 0, mii_rx_clk_i = 0, power_save_exit_i = 0;
    logic        crossover_enable_strap_i = 0, reversal_detected_i = 0, reversal_manual_i = 0;
    logic        eeprom_data_pin_o, eeprom_data_pin_oe_n_o, eeprom_clock_pin_o, eeprom_chip_select_o, ee_din_o;
    logic        bus_width_32_o, host_wr_ok_o, pair_swap_o, sys_rst_o, mdl_d, mdl_oe_n;
    wire         eeprom_data_pin_i;
    int          fails = 0, checks_done = 0;
    logic        exp_d, exp_c;
    logic [31:0] rng = 32'h0000_0016;
    always #5 clk_i = ~clk_i;
    // device wins when driving, then the eeprom, else the strap resistor
    assign eeprom_data_pin_i = !eeprom_data_pin_oe_n_o ? eeprom_data_pin_o : !mdl_oe_n ? mdl_d : strap_lvl;
    epm_pin_mux uut (.clk_i, .rst_i, .reset_in_n_i, .data_func_i, .clock_func_i, .func_load_i, .ee_cs_req_i,
        .ee_clk_req_i, .ee_dout_i, .ee_doe_i, .general_output_a_i, .general_output_b_i, .mii_tx_en_i,
        .mii_tx_clk_i, .mii_rx_dv_i, .mii_rx_clk_i, .eeprom_data_pin_i, .eeprom_data_pin_o,
        .eeprom_data_pin_oe_n_o, .eeprom_clock_pin_o, .eeprom_chip_select_o, .ee_din_o, .bus_width_32_o,
        .host_rd_i, .host_wr_i, .power_save_exit_i, .host_wr_ok_o, .crossover_enable_strap_i,
        .reversal_detected_i, .reversal_manual_i, .pair_swap_o, .sys_rst_o);
    epm_eeprom_model eeprom (.clk_i, .rst_i, .chip_select_i(eeprom_chip_select_o),
        .serial_clock_i(eeprom_clock_pin_o), .read_phase_i(read_phase), .data_o(mdl_d), .data_oe_n_o(mdl_oe_n));
    function automatic logic rnd();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng[0];
    endfunction
    // expected pin value for a function select
    function automatic logic pick(input logic [1:0] f, input logic a, input logic b, input logic c, input logic d);
        return f == 2'h0 ? a : f == 2'h1 ? b : f == 2'h2 ? c : d;
    endfunction
    task automatic chk(input logic got, input logic exp, input string what);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: %s", $time, what);
        end
    endtask
    task automatic complete_run();
        if (fails == 0 && checks_done > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_i);
    endtask
    // bounded wait for the internal reset to drop
    task automatic wait_run();
        for (int i = 0; i < 60 && sys_rst_o !== 1'b0; i++) cyc(1);
        if (sys_rst_o !== 1'b0) begin
            fails++;
            complete_run();
        end
    endtask
    task automatic do_reset(input logic bw, input logic xov);
        strap_lvl = bw;
        crossover_enable_strap_i = xov;
        rst_i = 1;
        cyc(5);
        chk(eeprom_data_pin_oe_n_o, 1'b1, "pin released in reset");
        chk(sys_rst_o, 1'b1, "internal reset held");
        rst_i = 0;
        wait_run();
        strap_lvl = ~bw;
        crossover_enable_strap_i = ~xov;
        cyc(6);
        chk(bus_width_32_o, bw, "bus width not latched");
    endtask
    initial begin
        for (int r = 0; r < 4; r++) begin
            do_reset(r[0], r[1]);
            // writes refused until a read, relocked on power-save exit
            host_wr_i = 1;
            #1 chk(host_wr_ok_o, 1'b0, "write before read");
            cyc(1);
            host_wr_i = 0;
            host_rd_i = 1;
            cyc(1);
            host_rd_i = 0;
            host_wr_i = 1;
            #1 chk(host_wr_ok_o, 1'b1, "write after read");
            cyc(1);
            host_wr_i = 0;
            power_save_exit_i = 1;
            cyc(1);
            power_save_exit_i = 0;
            host_wr_i = 1;
            #1 chk(host_wr_ok_o, 1'b0, "write after power save");
            cyc(1);
            host_wr_i = 0;
            for (int s = 0; s < 4; s++) begin
                {reversal_detected_i, reversal_manual_i} = s[1:0];
                cyc(4);
                chk(pair_swap_o, (r[1] & s[1]) | s[0], "pair swap");
            end
        end
        ee_cs_req_i = 1;
        cyc(3);
        chk(eeprom_chip_select_o, 1'b1, "eeprom mode after reset");
        // every pair of pin functions with random pin sources
        for (int k = 0; k < 17; k++) begin
            data_func_i  = epm_func_e'(k[1:0]);
            clock_func_i = epm_func_e'(k[3:2]);
            {ee_clk_req_i, ee_dout_i, ee_doe_i} = {rnd(), rnd(), rnd()};
            {general_output_a_i, general_output_b_i} = {rnd(), rnd()};
            {mii_tx_en_i, mii_tx_clk_i, mii_rx_dv_i, mii_rx_clk_i} = {rnd(), rnd(), rnd(), rnd()};
            func_load_i = 1;
            cyc(1);
            func_load_i = 0;
            cyc(2);
            chk(eeprom_chip_select_o, k[3:0] == 4'h0, "chip select gating");
            chk(eeprom_data_pin_oe_n_o, k[1:0] == 2'h0 ? ~ee_doe_i : 1'b0, "data pin direction");
            exp_d = pick(k[1:0], ee_dout_i, general_output_a_i, mii_tx_en_i, mii_tx_clk_i);
            exp_c = pick(k[3:2], ee_clk_req_i, general_output_b_i, mii_rx_dv_i, mii_rx_clk_i);
            if (eeprom_data_pin_oe_n_o === 1'b0)
                chk(eeprom_data_pin_o, exp_d, "data pin");
            chk(eeprom_clock_pin_o, exp_c, "clock pin");
            if (k[1:0] != 2'h0)
                chk(ee_din_o, 1'b0, "input blocked while borrowed");
        end
        // eeprom answers on the data pin and the device hears it
        {ee_doe_i, ee_clk_req_i, read_phase} = 3'b001;
        for (int b = 0; b < 3; b++) begin
            ee_clk_req_i = b[0];
            cyc(5);
            chk(ee_din_o, mdl_d, "eeprom data in");
        end
        read_phase = 0;
        // strap opposite to the last latch, so a missed relatch shows
        strap_lvl = 0;
        reset_in_n_i = 0;
        cyc(4);
        chk(sys_rst_o, 1'b1, "reset pin");
        chk(eeprom_chip_select_o, 1'b0, "chip select in reset");
        reset_in_n_i = 1;
        wait_run();
        chk(bus_width_32_o, 1'b0, "strap on pin reset");
        host_wr_i = 1;
        #1 chk(host_wr_ok_o, 1'b0, "write before read after pin reset");
        cyc(1);
        host_wr_i = 0;
        complete_run();
    end
endmodule

// ### verification/epm_eeprom_model.sv
// serial eeprom model that sits on the shared data and clock pins
module epm_eeprom_model (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic chip_select_i,
    input  wire logic serial_clock_i,
    input  wire logic read_phase_i,
    output logic      data_o,
    output logic      data_oe_n_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] shift_q;
    logic       sclk_q;
    // rotate the stored pattern on each rising serial clock while selected
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            shift_q <= 8'ha5;
            sclk_q  <= 1'b0;
        end else begin
            sclk_q <= serial_clock_i;
            if (chip_select_i && serial_clock_i && !sclk_q)
                shift_q <= {shift_q[6:0], shift_q[7]};
        end
    end
    // drives only in its read phase, so the device has released the line
    assign data_oe_n_o = !(chip_select_i && read_phase_i);
    assign data_o      = shift_q[7];
endmodule
